// >>> rtl/ispc_pkg.sv
package ispc_pkg;
  // Register byte addresses (Avalon word aligned, index times four)
  localparam logic [7:0]  CHIP_PROGRAM_CONTROL_IDX = 8'hbf;
  localparam logic [9:0]  CHIP_PROGRAM_CONTROL_ADDR = 10'h2fc;
  localparam logic [9:0]  SECURITY_STATUS_ADDR     = 10'h000;
  localparam logic [9:0]  ISP_STATUS_ADDR          = 10'h004;
  // Control field positions
  localparam int SOFT_REBOOT_BIT   = 7;
  localparam int AUX_RAM_ON_BIT    = 4;
  localparam int LOADER_SEL_BIT    = 1;
  localparam int PROG_ENABLE_BIT   = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Security word fields
  localparam int LOCK_BIT          = 0;
  localparam int MOVC_INHIBIT_BIT  = 1;
  localparam int ENCRYPT_BIT       = 2;
  localparam int OSC_GAIN_BIT      = 7;
  localparam logic [15:0] SECURITY_WORD_ADDR = 16'hffff;
  localparam logic [7:0]  SECURITY_ERASED    = 8'hff;
  // Flash operation codes
  localparam logic [1:0] OP_READ    = 2'h0;
  localparam logic [1:0] OP_PROGRAM = 2'h1;
  localparam logic [1:0] OP_ERASE   = 2'h2;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  // Cycles of the chip-wide reboot pulse
  localparam int REBOOT_CYCLES = 4;
  typedef enum logic [1:0] {
    ISPC_NORMAL  = 2'b00,
    ISPC_ARMED   = 2'b01,
    ISPC_ISP     = 2'b10
  } ispc_mode_t;
endpackage

// >>> rtl/ispc_control.sv
// Behaviour
// - Soft reboot with loader select and program enable set resets the whole chip.
// - Soft reboot bit reads one while running in forced loader boot.
// - Aux RAM enable bit switches on-chip aux RAM on or off.
// - Loader select picks which bank runs the loader and which is target.
// - Programming mode entered only after idle then interrupt wake-up.
// - In programming mode the flash operation fires when core enters idle.
// - Program enable cleared makes flash read-only, rejecting erase and program.
// - After power-on execution starts from the application bank by default.
// - Forced loader boot at power-up starts execution from loader bank.
// - Security word cannot be accessed while in programming mode.
// - Programmed security bits stay zero until an erase-all.
// - Security word sits at address ffff of the loader bank.
// - Lock bit zero denies further access to flash and setting registers.
// - Inhibit zero: MOVC from external code reads only external memory.
// - MOVC from internal code may always read internal and external.
// - Inhibit one places no limit on MOVC reads.
// - Encryption enabled encodes port-0 output data.
// - Only whole-chip erase clears the encryption setting.
// - Oscillator gain bit zero halves the oscillator amplifier gain.
`timescale 1ns/1ps
module ispc_control #(
  parameter logic [7:0] ENCRYPT_KEY = 8'h5a  // Arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Core status
  input  wire logic        core_idle_i,
  input  wire logic        core_irq_wake_i,
  // Straps (pins)
  input  wire logic        strap_p26_i,
  input  wire logic        strap_p27_i,
  // Flash operation request from the core command registers
  input  wire logic        flash_req_i,
  input  wire logic [1:0]  flash_op_i,
  input  wire logic [15:0] flash_addr_i,
  input  wire logic        flash_erase_all_i,
  // Non-volatile security word image
  input  wire logic [7:0]  nv_security_i,
  // MOVC qualification
  input  wire logic        movc_i,
  input  wire logic        movc_from_internal_i,
  input  wire logic        movc_target_internal_i,
  output logic             movc_allow_o,
  // Port 0 data
  input  wire logic [7:0]  p0_data_i,
  output logic [7:0]       p0_data_o,
  // Flash controls
  output logic             flash_go_o,
  output logic             flash_target_loader_o,
  output logic             flash_reject_o,
  output logic             security_write_o,
  output logic [7:0]       security_wdata_o,
  // Chip controls
  output logic             chip_reset_o,
  output logic             boot_from_loader_o,
  output logic             aux_ram_on_o,
  output logic             osc_half_gain_o,
  output logic             isp_mode_o
);

  logic [7:0]  ctrl;
  logic        loader_boot_flag;
  logic [7:0]  sec;
  logic        sec_loaded;
  logic [2:0]  reboot_cnt;
  logic        s1_26;
  logic        s2_26;
  logic        s1_27;
  logic        s2_27;
  ispc_pkg::ispc_mode_t mode;
  logic        idle_q;
  logic        rd_pend;
  logic        locked;
  logic        ctrl_hit;
  logic        wr_ok;
  logic        idle_rise;
  logic        sec_target;

  // Reboot counter is three bits wide
  if (ispc_pkg::REBOOT_CYCLES < 1 || ispc_pkg::REBOOT_CYCLES > 7) begin : g_reboot_check
    $error("Reboot pulse length does not fit its counter");
  end

  // Bus answers in the cycle after the request is seen
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~rd_pend;
  assign ctrl_hit = avs_address_i == ispc_pkg::CHIP_PROGRAM_CONTROL_ADDR;
  assign locked   = sec_loaded & ~sec[ispc_pkg::LOCK_BIT];
  assign wr_ok    = avs_write_i & rd_pend & ctrl_hit & avs_byteenable_i[0] & ~locked;
  assign idle_rise = core_idle_i & ~idle_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= (avs_read_i | avs_write_i) & ~rd_pend;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= ispc_pkg::UNMAPPED_READ;
    end else if (avs_read_i & ~rd_pend) begin
      unique case (avs_address_i)
        ispc_pkg::CHIP_PROGRAM_CONTROL_ADDR:
          avs_readdata_o <= {24'h000000, loader_boot_flag, ctrl[6:0]};
        ispc_pkg::SECURITY_STATUS_ADDR:
          avs_readdata_o <= (mode == ispc_pkg::ISPC_ISP) ? ispc_pkg::UNMAPPED_READ
                                               : {24'h000000, sec};
        ispc_pkg::ISP_STATUS_ADDR:
          avs_readdata_o <= {28'h0000000, locked, sec_loaded, mode};
        default:
          avs_readdata_o <= ispc_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // Strap synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_26 <= 1'b1;
      s2_26 <= 1'b1;
      s1_27 <= 1'b1;
      s2_27 <= 1'b1;
    end else begin
      s1_26 <= strap_p26_i;
      s2_26 <= s1_26;
      s1_27 <= strap_p27_i;
      s2_27 <= s1_27;
    end
  end

  // straps sampled only during the reboot pulse; board keeps them safe
  // both straps low forces loader boot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loader_boot_flag <= 1'b0;
    end else if (reboot_cnt == 3'd1) begin
      loader_boot_flag <= ~s2_26 & ~s2_27;
    end
  end

  // soft reboot pulse stretches over several cycles for the whole chip
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reboot_cnt <= 3'(ispc_pkg::REBOOT_CYCLES);
    end else if (wr_ok & avs_writedata_i[ispc_pkg::SOFT_REBOOT_BIT]
                 & avs_writedata_i[ispc_pkg::LOADER_SEL_BIT]
                 & avs_writedata_i[ispc_pkg::PROG_ENABLE_BIT]) begin
      reboot_cnt <= 3'(ispc_pkg::REBOOT_CYCLES);
    end else if (reboot_cnt != 3'd0) begin
      reboot_cnt <= reboot_cnt - 3'd1;
    end
  end
  assign chip_reset_o = reboot_cnt != 3'd0;

  always_ff @(posedge clk_i) begin
    if (rst_i | chip_reset_o) begin
      ctrl <= ispc_pkg::CTRL_RESET;
    end else if (wr_ok) begin
      ctrl <= {1'b0, 2'b00, avs_writedata_i[4], 2'b00, avs_writedata_i[1:0]};
    end
  end

  // latch security word at reset release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec        <= ispc_pkg::SECURITY_ERASED;
      sec_loaded <= 1'b0;
    end else if (flash_go_o & flash_erase_all_i) begin
      sec <= ispc_pkg::SECURITY_ERASED;
    end else if (!sec_loaded) begin
      sec        <= nv_security_i;
      sec_loaded <= 1'b1;
    end else if (security_write_o) begin
      sec <= sec & security_wdata_o;
    end
  end

  // armed by idle, entered on interrupt wake
  always_ff @(posedge clk_i) begin
    if (rst_i | chip_reset_o) begin
      mode   <= ispc_pkg::ISPC_NORMAL;
      idle_q <= 1'b0;
    end else begin
      idle_q <= core_idle_i;
      unique case (mode)
        ispc_pkg::ISPC_NORMAL: begin
          if (ctrl[ispc_pkg::PROG_ENABLE_BIT] & idle_rise) mode <= ispc_pkg::ISPC_ARMED;
        end
        ispc_pkg::ISPC_ARMED: begin
          if (core_irq_wake_i) mode <= ispc_pkg::ISPC_ISP;
        end
        ispc_pkg::ISPC_ISP: begin
          if (!ctrl[ispc_pkg::PROG_ENABLE_BIT]) mode <= ispc_pkg::ISPC_NORMAL;
        end
        default: mode <= ispc_pkg::ISPC_NORMAL;
      endcase
    end
  end

  // security word at ffff of loader bank
  assign sec_target = flash_target_loader_o & (flash_addr_i == ispc_pkg::SECURITY_WORD_ADDR);
  assign flash_target_loader_o = ~ctrl[ispc_pkg::LOADER_SEL_BIT];

  // operation fires on idle entry in programming mode
  // writes rejected when program enable low
  // security word blocked in programming mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_go_o       <= 1'b0;
      flash_reject_o   <= 1'b0;
      security_write_o <= 1'b0;
      security_wdata_o <= 8'h00;
    end else begin
      flash_go_o <= flash_req_i & idle_rise & (mode == ispc_pkg::ISPC_ISP) & ~locked
                    & ~sec_target & ctrl[ispc_pkg::PROG_ENABLE_BIT];
      // One reject pulse per request, on the same idle entry that would start it
      flash_reject_o <= flash_req_i & idle_rise & ((flash_op_i != ispc_pkg::OP_READ
                        & ~ctrl[ispc_pkg::PROG_ENABLE_BIT]) | locked
                        | (sec_target & (mode == ispc_pkg::ISPC_ISP)));
      security_write_o <= 1'b0;
      security_wdata_o <= 8'h00;
    end
  end

  assign movc_allow_o = ~movc_i | movc_from_internal_i | ~movc_target_internal_i
                        | sec[ispc_pkg::MOVC_INHIBIT_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p0_data_o <= 8'h00;
    end else begin
      p0_data_o <= sec[ispc_pkg::ENCRYPT_BIT] ? p0_data_i
                                              : {p0_data_i[0], p0_data_i[7:1]} ^ ENCRYPT_KEY;
    end
  end

  // gain halved when bit is zero
  assign osc_half_gain_o    = ~sec[ispc_pkg::OSC_GAIN_BIT];
  assign boot_from_loader_o = loader_boot_flag;
  assign aux_ram_on_o       = ctrl[ispc_pkg::AUX_RAM_ON_BIT];
  assign isp_mode_o         = mode == ispc_pkg::ISPC_ISP;

  // Control reaches reset value one cycle after reboot
  a_reboot_clears:
    assert property (@(posedge clk_i) disable iff (rst_i)
      chip_reset_o |=> (ctrl == ispc_pkg::CTRL_RESET))
    else $error("Control not cleared by reboot");

  a_reboot_length:
    assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(chip_reset_o) |-> chip_reset_o [*4] ##1 !chip_reset_o)
    else $error("Reboot pulse has wrong length");

  a_reboot_trigger:
    assert property (@(posedge clk_i) disable iff (rst_i)
      wr_ok & avs_writedata_i[7] & avs_writedata_i[1] & avs_writedata_i[0] |=> chip_reset_o)
    else $error("Soft reboot write ignored");

  a_flag_readback:
    assert property (@(posedge clk_i) disable iff (rst_i)
      avs_read_i & !rd_pend & ctrl_hit |=> avs_readdata_o[7] == $past(loader_boot_flag))
    else $error("Loader boot flag not read back");

  a_aux_follows:
    assert property (@(posedge clk_i) disable iff (rst_i)
      wr_ok & !chip_reset_o |=> aux_ram_on_o == $past(avs_writedata_i[4]))
    else $error("Aux RAM enable not applied");

  a_target_bank:
    assert property (@(posedge clk_i) disable iff (rst_i)
      wr_ok & !chip_reset_o |=> flash_target_loader_o == !$past(avs_writedata_i[1]))
    else $error("Wrong reprogramming target bank");

  a_isp_entry_path:
    assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(isp_mode_o) |-> $past(mode == ispc_pkg::ISPC_ARMED))
    else $error("Programming mode entered without idle wake");

  a_isp_wake:
    assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(isp_mode_o) |-> $past(core_irq_wake_i))
    else $error("Programming mode entered without interrupt");

  a_go_on_idle:
    assert property (@(posedge clk_i) disable iff (rst_i)
      flash_go_o |-> $past(idle_rise) && $past(isp_mode_o))
    else $error("Flash operation outside idle entry");

  a_reject_disabled:
    assert property (@(posedge clk_i) disable iff (rst_i)
      flash_req_i & idle_rise & (flash_op_i != ispc_pkg::OP_READ)
      & !ctrl[ispc_pkg::PROG_ENABLE_BIT] |=> flash_reject_o & !flash_go_o)
    else $error("Write operation not rejected");

  a_default_boot:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (reboot_cnt == 3'd1) & (s2_26 | s2_27) |=> !boot_from_loader_o)
    else $error("Loader boot without both straps");

  a_forced_boot:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (reboot_cnt == 3'd1) & !s2_26 & !s2_27 |=> boot_from_loader_o)
    else $error("Forced loader boot missed");

  a_sec_hidden:
    assert property (@(posedge clk_i) disable iff (rst_i)
      avs_read_i & !rd_pend & isp_mode_o
      & (avs_address_i == ispc_pkg::SECURITY_STATUS_ADDR)
      |=> avs_readdata_o == ispc_pkg::UNMAPPED_READ)
    else $error("Security word visible in programming mode");

  a_sec_word_blocked:
    assert property (@(posedge clk_i) disable iff (rst_i)
      flash_go_o |-> !$past(sec_target))
    else $error("Flash operation on security word");

  a_lock_ctrl:
    assert property (@(posedge clk_i) disable iff (rst_i)
      locked & avs_write_i & !chip_reset_o |=> $stable(ctrl))
    else $error("Control changed while locked");

  a_read_only_flash:
    assert property (@(posedge clk_i) disable iff (rst_i)
      flash_go_o |-> $past(ctrl[ispc_pkg::PROG_ENABLE_BIT]))
    else $error("Flash operation while disabled");
  a_lock_denies:
    assert property (@(posedge clk_i) disable iff (rst_i)
      flash_go_o |-> !$past(locked))
    else $error("Flash access while locked");
  a_movc_limit:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (movc_i & ~movc_from_internal_i & movc_target_internal_i
       & ~sec[ispc_pkg::MOVC_INHIBIT_BIT]) |-> !movc_allow_o)
    else $error("External MOVC read internal code");
  a_movc_internal:
    assert property (@(posedge clk_i) disable iff (rst_i)
      movc_from_internal_i |-> movc_allow_o)
    else $error("Internal MOVC blocked");

  a_movc_free:
    assert property (@(posedge clk_i) disable iff (rst_i)
      sec[ispc_pkg::MOVC_INHIBIT_BIT] |-> movc_allow_o)
    else $error("MOVC limited with inhibit off");

  a_encrypt_off:
    assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) & $past(sec[ispc_pkg::ENCRYPT_BIT]) |-> p0_data_o == $past(p0_data_i))
    else $error("Port data altered without encryption");

  a_gain_full:
    assert property (@(posedge clk_i) disable iff (rst_i)
      sec[ispc_pkg::OSC_GAIN_BIT] |-> !osc_half_gain_o)
    else $error("Gain reduced with bit set");

  a_sec_latched:
    assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(sec_loaded) |-> sec == $past(nv_security_i))
    else $error("Security word not latched");
  a_gain_half:
    assert property (@(posedge clk_i) disable iff (rst_i)
      sec_loaded & !sec[ispc_pkg::OSC_GAIN_BIT] |-> osc_half_gain_o)
    else $error("Gain not reduced");
  a_sec_sticky:
    assert property (@(posedge clk_i) disable iff (rst_i)
      sec_loaded & $past(sec_loaded) & !$past(flash_go_o & flash_erase_all_i)
      |-> ((sec & ~$past(sec)) == 8'h00))
    else $error("Security bit returned to one");

endmodule // ispc_control

// >>> bench/ispc_core_model.sv
`timescale 1ns/1ps
module ispc_core_model (
  input  wire logic        clk_i,
  output logic             idle_o,
  output logic             wake_o,
  output logic             req_o,
  output logic [1:0]       op_o,
  output logic [15:0]      addr_o,
  output logic             key_a_o,
  output logic             key_b_o
);
  initial begin
    {idle_o, wake_o, req_o, op_o, addr_o} = '0;
    {key_a_o, key_b_o} = 2'b11;
  end
  task automatic keys(input logic down);
    @(posedge clk_i);
    {key_a_o, key_b_o} <= {2{~down}};
  endtask
  task automatic idle_wake();
    @(posedge clk_i);
    idle_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    {idle_o, wake_o} <= 2'b01;
    @(posedge clk_i);
    wake_o <= 1'b0;
  endtask
  task automatic idle_op(input logic [1:0] op);
    @(posedge clk_i);
    {req_o, op_o, addr_o} <= {1'b1, op, 16'h1234};
    @(posedge clk_i);
    idle_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    // Released address flips so a stale value never looks valid
    {idle_o, req_o, addr_o} <= {2'b00, 16'hedcb};
    @(posedge clk_i);
  endtask
endmodule // ispc_core_model

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [9:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [3:0]  avs_byteenable_i;
  logic        core_idle_i, core_irq_wake_i, strap_p26_i, strap_p27_i, flash_req_i;
  logic [1:0]  flash_op_i;
  logic [15:0] flash_addr_i;
  logic        flash_erase_all_i, movc_i, movc_from_internal_i, movc_target_internal_i;
  logic        movc_allow_o, flash_go_o, flash_target_loader_o, flash_reject_o;
  logic        security_write_o, chip_reset_o, boot_from_loader_o, aux_ram_on_o;
  logic        osc_half_gain_o, isp_mode_o;
  logic [7:0]  nv_security_i, p0_data_i, p0_data_o, security_wdata_o;
  int          miscompares, checked, cyc, go_n, rej_n, rb_n;
  // Row: security, movc from internal, movc to internal, allow, half gain, control readback
  logic [19:0] rows [7] = '{20'hff613, 20'hfd413, 20'hfd213, 20'hfde13, 20'h7fb13,
                            20'hfe600, 20'hfb613};
  localparam logic [9:0] CA = ispc_pkg::CHIP_PROGRAM_CONTROL_ADDR;

  ispc_control ispc_control_i (
    .clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .core_idle_i, .core_irq_wake_i,
    .strap_p26_i, .strap_p27_i, .flash_req_i, .flash_op_i, .flash_addr_i, .flash_erase_all_i,
    .nv_security_i, .movc_i, .movc_from_internal_i, .movc_target_internal_i, .movc_allow_o,
    .p0_data_i, .p0_data_o, .flash_go_o, .flash_target_loader_o, .flash_reject_o,
    .security_write_o, .security_wdata_o, .chip_reset_o, .boot_from_loader_o, .aux_ram_on_o,
    .osc_half_gain_o, .isp_mode_o);
  ispc_core_model ispc_core_model_i (
    .clk_i, .idle_o(core_idle_i), .wake_o(core_irq_wake_i), .req_o(flash_req_i),
    .op_o(flash_op_i), .addr_o(flash_addr_i), .key_a_o(strap_p26_i), .key_b_o(strap_p27_i));

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (flash_go_o === 1'b1) go_n++;
    if (flash_reject_o === 1'b1) rej_n++;
    if (chip_reset_o === 1'b1) rb_n++;
    if (cyc == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Counts: checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Waitrequest and read data are taken at the rising edge; a wait ends when waitrequest is low, or at the timeout
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic reset_with(input logic [7:0] sec);
    @(posedge clk_i);
    rst_i <= 1'b1;
    nv_security_i <= sec;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  initial begin
    clk_i = 1'b0;
    {rst_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    {flash_erase_all_i, movc_from_internal_i, movc_target_internal_i} = '0;
    avs_byteenable_i = 4'hf;
    movc_i = 1'b1;
    p0_data_i = 8'h3c;
    nv_security_i = 8'hff;
    foreach (rows[i]) begin
      reset_with(rows[i][19:12]);
      movc_from_internal_i <= rows[i][11];
      movc_target_internal_i <= rows[i][10];
      bus(1'b1, CA, 32'h13);
      bus(1'b0, CA, 32'h0);
      chk(q, {24'h0, rows[i][7:0]});
      chk(aux_ram_on_o, rows[i][4]);
      chk(movc_allow_o, rows[i][9]);
      chk(osc_half_gain_o, rows[i][8]);
      chk(p0_data_o === 8'h3c, rows[i][14]);
      chk(boot_from_loader_o, 1'b0);
      $display("Row %0d done", i);
    end
    reset_with(8'hff);
    go_n = 0;
    rej_n = 0;
    bus(1'b1, CA, 32'h01);
    ispc_core_model_i.idle_wake();
    @(negedge clk_i);
    chk(isp_mode_o, 1'b1);
    bus(1'b0, ispc_pkg::SECURITY_STATUS_ADDR, 32'h0);
    chk(q, 32'h0);
    ispc_core_model_i.idle_op(ispc_pkg::OP_PROGRAM);
    chk(go_n, 1);
    chk(flash_target_loader_o, 1'b1);
    bus(1'b1, CA, 32'h03);
    @(negedge clk_i);
    chk(flash_target_loader_o, 1'b0);
    bus(1'b1, CA, 32'h00);
    ispc_core_model_i.idle_op(ispc_pkg::OP_ERASE);
    chk(rej_n, 1);
    chk(go_n, 1);
    bus(1'b0, 10'h100, 32'h0);
    chk(q, ispc_pkg::UNMAPPED_READ);
    $display("Programming flow done");
    ispc_core_model_i.keys(1'b1);
    rb_n = 0;
    bus(1'b1, CA, 32'h83);
    repeat (8) @(posedge clk_i);
    chk(rb_n, ispc_pkg::REBOOT_CYCLES);
    chk(boot_from_loader_o, 1'b1);
    bus(1'b0, CA, 32'h0);
    chk(q[7], 1'b1);
    ispc_core_model_i.keys(1'b0);
    $display("Soft reboot done");
    wrap_up();
  end
endmodule // tb_top
